// ---- logic/bmpt_consts.vh ----
// Purpose: Constants of the board memory pattern tester
// Assumes: AHB-Lite register slave, 32-bit word registers
// Notes: Included by bmpt_top.v only
`ifndef BMPT_CONSTS_VH
`define BMPT_CONSTS_VH

`define BMPT_OFF_CTRL 8'h00
`define BMPT_OFF_BOARD_SEL 8'h04
`define BMPT_OFF_BOARD_EN 8'h08
`define BMPT_OFF_START_LOC 8'h0C
`define BMPT_OFF_LOC_TOTAL 8'h10
`define BMPT_OFF_PAT_START 8'h14
`define BMPT_OFF_MASK 8'h18
`define BMPT_OFF_STATUS 8'h1C
`define BMPT_OFF_ERR_COUNT 8'h20
`define BMPT_OFF_FAIL_ADDR 8'h24
`define BMPT_OFF_FAIL_EXP 8'h28
`define BMPT_OFF_FAIL_READ 8'h2C
`define BMPT_OFF_STRIDE 8'h30

`define BMPT_CTRL_START 0
`define BMPT_CTRL_ALL 1
`define BMPT_ST_BUSY 0
`define BMPT_ST_PASS 1
`define BMPT_ST_FAIL 2
`define BMPT_ST_ABORT 3

`define BMPT_RST_WORD 32'h0000_0000
`define BMPT_RST_STRIDE 32'h0000_1000
`define BMPT_RST_EN 12'h000

`define BMPT_BOARDS 4'hC
`define BMPT_BLK 5'h10
`define BMPT_TWO_ONES 8'h78
`define BMPT_TWO_ZEROS_END 8'hF0
`define BMPT_ALT_EVEN 16'h5555
`define BMPT_ALT_ODD 16'hAAAA
`define BMPT_WORD_STEP 32'h0000_0004

`endif

// ---- logic/bmpt_top.v ----
// Purpose: Memory pattern self-test engine with AHB-Lite registers
// Assumes: Memory port on mclk; one access outstanding at a time
// Notes: Registers answer with zero wait states
`timescale 1ns/1ps
`default_nettype none
`include "bmpt_consts.vh"

module bmpt_top #(
	parameter ERR_W = 16
) (
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire mem_req,
	output reg mem_we,
	output reg [31:0] mem_addr,
	output reg [31:0] mem_wdata,
	input wire [31:0] mem_rdata,
	input wire mem_ack,
	input wire mem_err
);

	localparam S_IDLE = 3'd0;
	localparam S_SEEK = 3'd1;
	localparam S_BLOCK = 3'd2;
	localparam S_ISSUE = 3'd3;
	localparam S_XFER = 3'd4;

	// Pattern table as a function of entry index
	function [31:0] bmpt_pat;
		input [7:0] k;
		reg [15:0] v;
		reg [7:0] n;
		reg [7:0] kk;
		integer i;
		integer j;
		begin
			v = 16'h0000;
			n = 8'h00;
			kk = (k < `BMPT_TWO_ONES) ? k : k - `BMPT_TWO_ONES;
			for (j = 1; j < 16; j = j + 1) begin
				for (i = 0; i < j; i = i + 1) begin
					if (n == kk)
						v = (16'h0001 << i) | (16'h0001 << j);
					n = n + 8'h01;
				end
			end
			if (k >= `BMPT_TWO_ZEROS_END)
				v = k[0] ? `BMPT_ALT_ODD : `BMPT_ALT_EVEN;
			else if (k >= `BMPT_TWO_ONES)
				v = ~v;
			bmpt_pat = {v, v};
		end
	endfunction

	reg [7:0] a_addr_reg;
	reg a_wr_reg;
	reg a_valid_reg;
	reg mode_all_reg;
	reg [3:0] board_sel_reg;
	reg [11:0] board_en_reg;
	reg [31:0] start_loc_reg;
	reg [31:0] loc_total_reg;
	reg [7:0] pat_start_reg;
	reg [31:0] mask_reg;
	reg [31:0] stride_reg;
	reg busy_reg;
	reg pass_reg;
	reg fail_reg;
	reg abort_reg;
	reg [ERR_W-1:0] err_cnt_reg;
	reg [31:0] fail_addr_reg;
	reg [31:0] fail_exp_reg;
	reg [31:0] fail_read_reg;
	reg [2:0] state_reg;
	reg [3:0] board_reg;
	reg single_done_reg;
	reg [31:0] blk_base_reg;
	reg [31:0] rem_reg;
	reg [4:0] blk_len_reg;
	reg [3:0] grp_reg;
	reg [3:0] pss_reg;
	reg [3:0] idx_reg;
	reg wr_phase_reg;

	wire wr_data = a_valid_reg && a_wr_reg;
	wire start = wr_data && (a_addr_reg == `BMPT_OFF_CTRL) && hwdata[`BMPT_CTRL_START] && !busy_reg;
	wire [3:0] rot = idx_reg + pss_reg;
	wire [7:0] entry = pat_start_reg + {grp_reg, rot};
	wire [31:0] cur_addr = blk_base_reg + {26'h0, idx_reg, 2'b00};
	wire last_idx = ({1'b0, idx_reg} == blk_len_reg - 5'h01);
	wire mismatch = |((mem_rdata ^ mem_wdata) & ~mask_reg);
	wire [31:0] board_base = start_loc_reg + {28'h0, board_reg} * stride_reg;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign mem_req = (state_reg == S_XFER);

	// AHB address phase capture
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			a_addr_reg <= 8'h00;
			a_wr_reg <= 1'b0;
			a_valid_reg <= 1'b0;
		end else if (hready) begin
			a_valid_reg <= hsel && htrans[1] && (hsize == 3'h2) && (haddr[31:8] == 24'h00_0000) &&
				(haddr[1:0] == 2'b00);
			a_addr_reg <= haddr[7:0];
			a_wr_reg <= hwrite;
		end
	end

	// Register writes
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_all_reg <= 1'b0;
			board_sel_reg <= 4'h0;
			board_en_reg <= `BMPT_RST_EN;
			start_loc_reg <= `BMPT_RST_WORD;
			loc_total_reg <= `BMPT_RST_WORD;
			pat_start_reg <= 8'h00;
			mask_reg <= `BMPT_RST_WORD;
			stride_reg <= `BMPT_RST_STRIDE;
		end else if (wr_data && !busy_reg) begin
			case (a_addr_reg)
				`BMPT_OFF_CTRL: mode_all_reg <= hwdata[`BMPT_CTRL_ALL];
				`BMPT_OFF_BOARD_SEL: board_sel_reg <= hwdata[3:0];
				`BMPT_OFF_BOARD_EN: board_en_reg <= hwdata[11:0];
				`BMPT_OFF_START_LOC: start_loc_reg <= hwdata;
				`BMPT_OFF_LOC_TOTAL: loc_total_reg <= hwdata;
				`BMPT_OFF_PAT_START: pat_start_reg <= hwdata[7:0];
				`BMPT_OFF_MASK: mask_reg <= hwdata;
				`BMPT_OFF_STRIDE: stride_reg <= hwdata;
				default: ;
			endcase
		end
	end

	// Register reads
	always @* begin
		hrdata = 32'h0000_0000;
		if (a_valid_reg && !a_wr_reg) begin
			case (a_addr_reg)
				`BMPT_OFF_CTRL: hrdata = {30'h0, mode_all_reg, 1'b0};
				`BMPT_OFF_BOARD_SEL: hrdata = {28'h0, board_sel_reg};
				`BMPT_OFF_BOARD_EN: hrdata = {20'h0, board_en_reg};
				`BMPT_OFF_START_LOC: hrdata = start_loc_reg;
				`BMPT_OFF_LOC_TOTAL: hrdata = loc_total_reg;
				`BMPT_OFF_PAT_START: hrdata = {24'h0, pat_start_reg};
				`BMPT_OFF_MASK: hrdata = mask_reg;
				`BMPT_OFF_STATUS: hrdata = {24'h0, board_reg, abort_reg, fail_reg, pass_reg, busy_reg};
				`BMPT_OFF_ERR_COUNT: hrdata = {{(32-ERR_W){1'b0}}, err_cnt_reg};
				`BMPT_OFF_FAIL_ADDR: hrdata = fail_addr_reg;
				`BMPT_OFF_FAIL_EXP: hrdata = fail_exp_reg;
				`BMPT_OFF_FAIL_READ: hrdata = fail_read_reg;
				`BMPT_OFF_STRIDE: hrdata = stride_reg;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Test sequencer
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_IDLE;
			busy_reg <= 1'b0;
			pass_reg <= 1'b0;
			fail_reg <= 1'b0;
			abort_reg <= 1'b0;
			err_cnt_reg <= {ERR_W{1'b0}};
			fail_addr_reg <= `BMPT_RST_WORD;
			fail_exp_reg <= `BMPT_RST_WORD;
			fail_read_reg <= `BMPT_RST_WORD;
			board_reg <= 4'h0;
			single_done_reg <= 1'b0;
			blk_base_reg <= `BMPT_RST_WORD;
			rem_reg <= `BMPT_RST_WORD;
			blk_len_reg <= 5'h00;
			grp_reg <= 4'h0;
			pss_reg <= 4'h0;
			idx_reg <= 4'h0;
			wr_phase_reg <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= `BMPT_RST_WORD;
			mem_wdata <= `BMPT_RST_WORD;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						busy_reg <= 1'b1;
						pass_reg <= 1'b0;
						fail_reg <= 1'b0;
						abort_reg <= 1'b0;
						err_cnt_reg <= {ERR_W{1'b0}};
						board_reg <= hwdata[`BMPT_CTRL_ALL] ? 4'h0 : board_sel_reg;
						single_done_reg <= 1'b0;
						state_reg <= S_SEEK;
					end
				end
				S_SEEK: begin
					if (mode_all_reg ? (board_reg == `BMPT_BOARDS) : single_done_reg) begin
						busy_reg <= 1'b0;
						pass_reg <= (err_cnt_reg == {ERR_W{1'b0}});
						fail_reg <= (err_cnt_reg != {ERR_W{1'b0}});
						state_reg <= S_IDLE;
					end else if (mode_all_reg && !board_en_reg[board_reg]) begin
						board_reg <= board_reg + 4'h1;
					end else begin
						single_done_reg <= 1'b1;
						blk_base_reg <= board_base;
						rem_reg <= loc_total_reg;
						state_reg <= S_BLOCK;
					end
				end
				S_BLOCK: begin
					if (rem_reg == 32'h0000_0000) begin
						if (mode_all_reg)
							board_reg <= board_reg + 4'h1;
						state_reg <= S_SEEK;
					end else begin
						blk_len_reg <= (rem_reg >= {27'h0, `BMPT_BLK}) ? `BMPT_BLK : rem_reg[4:0];
						grp_reg <= 4'h0;
						pss_reg <= 4'h0;
						idx_reg <= 4'h0;
						wr_phase_reg <= 1'b1;
						state_reg <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					mem_we <= wr_phase_reg;
					mem_addr <= cur_addr;
					mem_wdata <= bmpt_pat(entry);
					state_reg <= S_XFER;
				end
				S_XFER: begin
					if (mem_err) begin
						busy_reg <= 1'b0;
						abort_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else if (mem_ack) begin
						state_reg <= S_ISSUE;
						if (!wr_phase_reg && mismatch) begin
							if (err_cnt_reg != {ERR_W{1'b1}})
								err_cnt_reg <= err_cnt_reg + {{(ERR_W-1){1'b0}}, 1'b1};
							fail_addr_reg <= mem_addr;
							fail_exp_reg <= mem_wdata;
							fail_read_reg <= mem_rdata;
						end
						if (!last_idx) begin
							idx_reg <= idx_reg + 4'h1;
						end else if (wr_phase_reg) begin
							idx_reg <= 4'h0;
							wr_phase_reg <= 1'b0;
						end else begin
							idx_reg <= 4'h0;
							wr_phase_reg <= 1'b1;
							pss_reg <= pss_reg + 4'h1;
							if (pss_reg == 4'hF) begin
								grp_reg <= grp_reg + 4'h1;
								if (grp_reg == 4'hF) begin
									rem_reg <= rem_reg - {27'h0, blk_len_reg};
									blk_base_reg <= blk_base_reg + {25'h0, blk_len_reg, 2'b00};
									state_reg <= S_BLOCK;
								end
							end
						end
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

endmodule // bmpt_top
`default_nettype wire

// ---- tb/bmpt_checker.sv ----
// Purpose: Assertions on bmpt_top ports
// Assumes: Single mclk domain
// Notes: Bound to bmpt_top below
`timescale 1ns/1ps
`default_nettype none
module bmpt_checker #(
	parameter ERR_W = 16
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic mem_err
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire st_rd = hsel && htrans[1] && hready && !hwrite && haddr == 32'h0000_001C;
	AST_HOLD: assert property (mem_req && !mem_ack && !mem_err |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
		else $error("request changed early");
	AST_GAP: assert property (mem_req && (mem_ack || mem_err) |=> !mem_req)
		else $error("request not dropped");
	AST_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned address");
	AST_HALVES: assert property (mem_req |-> mem_wdata[31:16] == mem_wdata[15:0])
		else $error("halves differ");
	AST_PAT: assert property (mem_req |-> $countones(mem_wdata) inside {4, 28} || mem_wdata[3:0] inside {4'h5, 4'hA})
		else $error("illegal pattern");
	AST_ABORT: assert property (mem_req && mem_err |=> !mem_req [*8])
		else $error("access after error");
	AST_BUSY: assert property (st_rd ##1 mem_req |-> hrdata[0])
		else $error("busy low during access");
	AST_ONE: assert property (st_rd |=> $onehot0(hrdata[3:1]))
		else $error("several results");
endmodule // bmpt_checker
bind bmpt_top bmpt_checker #(.ERR_W(ERR_W)) bmpt_checker_inst (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err));
`default_nettype wire

// ---- tb/bmpt_mem.sv ----
// Purpose: Memory under test behind the engine
// Assumes: 64 words, bit 0 may stick low
// Notes: Delay and error injection set by tb
`timescale 1ns/1ps
`default_nettype none
module bmpt_mem (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic stuck,
	input wire logic slow,
	input wire logic [15:0] err_at,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	output logic mem_err
);
	logic [31:0] mem [0:63];
	logic [1:0] dly;
	int n;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			dly <= 2'h0;
			n <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			// Stale data line, never the last value
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && !mem_err) begin
				if (dly != 2'h0) begin
					dly <= dly - 2'h1;
				end else begin
					n <= n + 1;
					dly <= slow ? n[1:0] : 2'h0;
					if (n + 1 == err_at) begin
						mem_err <= 1'b1;
					end else begin
						mem_ack <= 1'b1;
						if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
						mem_rdata <= mem[mem_addr[7:2]] & ~{31'h0000_0000, stuck};
					end
				end
			end
		end
	end
endmodule // bmpt_mem
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for bmpt_top
// Assumes: Zero wait register slave
// Notes: Monitor predicts every acknowledged memory access
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, stuck = 1'b0, slow = 1'b0, rdp, on = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdv, base, left, tot, mk, laddr, lexp, ecnt, e;
	logic [1:0] htrans = 2'h0;
	logic [15:0] err_at = 16'h0000;
	logic [7:0] ps;
	logic [3:0] stv;
	logic [31:0] bq[$];
	wire [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
	wire hreadyout, hresp, mem_req, mem_we, mem_ack, mem_err;
	int g, p, idx, len, fails = 0, comparisons = 0, cyc = 0, seed = 32'h6053;
	bmpt_top bmpt_top_inst (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err));
	bmpt_mem bmpt_mem_inst (.mclk(mclk), .arst_n(arst_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .stuck(stuck), .slow(slow), .err_at(err_at), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .mem_err(mem_err));
	always #50 mclk = ~mclk;
	function logic [15:0] tbl(input logic [7:0] k);
		int s, f, c;
		c = 0;
		tbl = k[0] ? 16'hAAAA : 16'h5555;
		for (s = 1; s < 16; s++) begin
			for (f = 0; f < s; f++) begin
				if (c == k) tbl = (16'h0001 << s) | (16'h0001 << f);
				if (c + 120 == k) tbl = ~((16'h0001 << s) | (16'h0001 << f));
				c++;
			end
		end
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task run(input logic [3:0] sel, input logic [11:0] en, input logic all, input logic [31:0] sl,
		input logic [31:0] n, input logic [7:0] s, input logic [31:0] m, input logic [3:0] x);
		int b;
		bus(1'b1, 8'h04, {28'h000_0000, sel});
		bus(1'b1, 8'h08, {20'h0_0000, en});
		bus(1'b1, 8'h0C, sl);
		bus(1'b1, 8'h10, n);
		bus(1'b1, 8'h14, {24'h00_0000, s});
		bus(1'b1, 8'h18, m);
		bq.delete();
		for (b = 0; b < 12; b++) if (all ? en[b] : b == sel) bq.push_back(sl + 32'(b) * 32'h0000_1000);
		base = bq.pop_front();
		{left, tot, ps, mk, ecnt, g, p, idx, rdp, on} = {n, n, s, m, 32'h0000_0000, 32'h0, 32'h0, 32'h0, 2'h1};
		bus(1'b1, 8'h00, {30'h0000_0000, all, 1'b1});
		bus(1'b0, 8'h1C, 32'h0000_0000);
		chk(rdv[0], 1'b1);
		do bus(1'b0, 8'h1C, 32'h0000_0000); while (rdv[0] === 1'b1);
		stv = rdv[3:0];
		on = 1'b0;
		bus(1'b0, 8'h20, 32'h0000_0000);
		chk(stv, x);
		chk(rdv, ecnt);
		$display("test run sel %0d done", sel);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			complete_run;
		end else if (on && mem_req && mem_ack) begin
			len = left < 16 ? left : 16;
			e = {2{tbl(ps + 8'(16 * g + (idx + p) % 16))}};
			chk(mem_we, !rdp);
			chk(mem_addr, base + 32'(4 * idx));
			chk(mem_wdata, e);
			if (rdp && stuck && e[0] && !mk[0]) begin
				ecnt++;
				laddr = base + 32'(4 * idx);
				lexp = e;
			end
			idx++;
			if (idx == len) begin
				idx = 0;
				rdp = !rdp;
				p = p + !rdp;
				if (p == 16) begin
					p = 0;
					g++;
				end
				if (g == 16) begin
					g = 0;
					base = base + 32'(4 * len);
					left = left - len;
					if (left == 0 && bq.size() > 0) begin
						base = bq.pop_front();
						left = tot;
					end
				end
			end
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		bus(1'b0, 8'h30, 32'h0000_0000);
		chk(rdv, 32'h0000_1000);
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		bus(1'b0, 8'hFC, 32'h0000_0000);
		chk(rdv, 32'h0000_0000);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		$display("test registers done");
		run(4'($unsigned($random(seed)) % 12), 12'h000, 1'b0, $random(seed) & 32'h0000_00C0, 32'd20,
			8'($random(seed)), 32'h0000_0000, 4'h2);
		{stuck, slow} <= 2'h3;
		run(4'($unsigned($random(seed)) % 12), 12'h000, 1'b0, 32'h0000_0040, 32'd3, 8'h00, 32'h0000_0000, 4'h4);
		bus(1'b0, 8'h24, 32'h0000_0000);
		chk(rdv, laddr);
		bus(1'b0, 8'h28, 32'h0000_0000);
		chk(rdv, lexp);
		bus(1'b0, 8'h2C, 32'h0000_0000);
		chk(rdv, lexp & 32'hFFFF_FFFE);
		slow <= 1'b0;
		run(4'h1, 12'h000, 1'b0, 32'h0000_0080, 32'd2, 8'($random(seed)), $random(seed) | 32'h0000_0001, 4'h2);
		stuck <= 1'b0;
		run(4'h0, 12'h024, 1'b1, 32'h0000_0000, 32'd1, 8'h78, 32'h0000_0000, 4'h2);
		err_at <= 16'(bmpt_mem_inst.n + 5);
		run(4'h6, 12'h000, 1'b0, 32'h0000_0000, 32'd4, 8'hF0, 32'h0000_0000, 4'h8);
		complete_run;
	end
endmodule // tb
`default_nettype wire
